// ### hdl/pdpo_consts.vh
`ifndef PDPO_CONSTS_VH
`define PDPO_CONSTS_VH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define PDPO_IDX_P0_DIR 8'hb8
`define PDPO_IDX_P1_DIR 8'hc1
`define PDPO_IDX_P2_DIR 8'hc2
`define PDPO_IDX_P5_DIR 8'hc5
`define PDPO_IDX_P0_PU 8'he0
`define PDPO_IDX_P1_PU 8'he1
`define PDPO_IDX_P2_PU 8'he2
`define PDPO_IDX_P5_PU 8'he5
`define PDPO_IDX_OD_CTRL 8'he9
`define PDPO_IDX_DIR_SET 8'hf0
`define PDPO_IDX_DIR_CLR 8'hf1
`define PDPO_IDX_PIN_LEVEL 8'hf2

// ****************************************************************
// Implemented bits per port
// ****************************************************************
`define PDPO_P0_DIR_MASK 8'h01
`define PDPO_P1_DIR_MASK 8'h0d
`define PDPO_P2_DIR_MASK 8'h3f
`define PDPO_P5_DIR_MASK 8'h10
`define PDPO_P0_PU_MASK 8'h01
`define PDPO_P1_PU_MASK 8'h0d
`define PDPO_P2_PU_MASK 8'h3f
`define PDPO_P5_PU_MASK 8'h10
`define PDPO_OD_MASK 8'h01

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PDPO_INPUT_ONLY_BIT 1
`define PDPO_OD_ENABLE_BIT 0
`define PDPO_OD_PIN 8
`define PDPO_SEL_LSB 8
`define PDPO_SEL_MSB 9
`define PDPO_DIR_RESET 8'h00
`define PDPO_PU_RESET 8'h00
`define PDPO_OD_RESET 8'h00

`endif

// ### hdl/pdpo_pin_cell.v
`default_nettype none
`include "pdpo_consts.vh"

// ****************************************************************
// Pad drive for all port pins, one generate slice per pin
// ****************************************************************
module pdpo_pin_cell #(
	parameter NPINS = 32
) (
	input wire clk,
	input wire rst_b,
	input wire [NPINS-1:0] dir,
	input wire [NPINS-1:0] dir_impl,
	input wire [NPINS-1:0] pull,
	input wire [NPINS-1:0] pull_impl,
	input wire [NPINS-1:0] od_en,
	input wire [NPINS-1:0] data,
	output wire [NPINS-1:0] pad_o,
	output wire [NPINS-1:0] pad_oe,
	output wire [NPINS-1:0] pad_pu
);
	genvar g;
	generate
		for (g = 0; g < NPINS; g = g + 1) begin : g_pin
			reg o_q;
			reg oe_q;
			reg pu_q;
			wire drive;
			wire odm;
			assign drive = dir[g] & dir_impl[g];
			assign odm = od_en[g] & drive;
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					o_q <= 1'b0;
					oe_q <= 1'b0;
					pu_q <= 1'b0;
				end else begin
					// Open drain only pulls low; a high lets the external resistor win
					o_q <= odm ? 1'b0 : data[g];
					oe_q <= odm ? ~data[g] : drive;
					pu_q <= pull[g] & pull_impl[g];
				end
			end
			assign pad_o[g] = o_q;
			assign pad_oe[g] = oe_q;
			assign pad_pu[g] = pu_q;
		end
	endgenerate
endmodule // pdpo_pin_cell

`default_nettype wire

// ### hdl/pdpo_port_cfg.v
// Functional notes
// - A direction bit of 0 makes its pin an input and 1 makes it a driven output.
// - Direction bits can be set or cleared one by one as well as written as a byte.
// - Port 1 pin 1 is input only and its direction bit always reads back as 1.
// - Port 1 pin 1 has no pull-up and its pull-up bit is held at 1.
// - Pull-up registers are write only, 1 enables a pull-up, and they reset to 0 except the held port 1 pin 1 bit.
// - Bit 0 of the open-drain register enables open drain on port 1 pin 0, reset 0.
// - In open drain the pin sinks for a low and releases for a high.
// - The open-drain register is write only and is updated by whole byte writes.
// - Leaving open drain returns the pin to what its direction bit selects.
// - All direction bits except the held port 1 pin 1 bit reset to 0 so every pin starts as an input.
`default_nettype none
`include "pdpo_consts.vh"

module pdpo_port_cfg (
	input wire clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [31:0] port_data,
	input wire [31:0] pin_i,
	output wire [31:0] pin_o,
	output wire [31:0] pin_oe,
	output wire [31:0] pin_pu
);
	// ****************************************************************
	// Port layout: byte 0 port 0, byte 1 port 1, byte 2 port 2, byte 3 port 5
	// ****************************************************************
	wire [31:0] dir_impl;
	wire [31:0] pu_impl;
	wire [31:0] od_vec;
	assign dir_impl = {`PDPO_P5_DIR_MASK, `PDPO_P2_DIR_MASK, `PDPO_P1_DIR_MASK,
		`PDPO_P0_DIR_MASK};
	assign pu_impl = {`PDPO_P5_PU_MASK, `PDPO_P2_PU_MASK, `PDPO_P1_PU_MASK,
		`PDPO_P0_PU_MASK};

	reg [7:0] dir0_q;
	reg [7:0] dir1_q;
	reg [7:0] dir2_q;
	reg [7:0] dir5_q;
	reg [7:0] pu0_q;
	reg [7:0] pu1_q;
	reg [7:0] pu2_q;
	reg [7:0] pu5_q;
	reg [7:0] od_q;
	reg [31:0] lvl_q;
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire [9:0] idx;
	wire setup;
	wire wr_en;
	wire [1:0] sel;
	wire [7:0] mask;
	assign idx = paddr[11:2];
	assign setup = psel & ~penable;
	// Writes land on the access edge that completes the transfer
	assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign sel = pwdata[`PDPO_SEL_MSB:`PDPO_SEL_LSB];
	assign mask = pwdata[7:0];

	wire hit_dir_set;
	wire hit_dir_clr;
	assign hit_dir_set = wr_en && idx == {2'b00, `PDPO_IDX_DIR_SET};
	assign hit_dir_clr = wr_en && idx == {2'b00, `PDPO_IDX_DIR_CLR};

	reg mapped;
	reg [7:0] rdata;
	always @* begin
		mapped = 1'b1;
		rdata = 8'h00;
		case (idx)
			{2'b00, `PDPO_IDX_P0_DIR}: rdata = dir0_q;
			{2'b00, `PDPO_IDX_P1_DIR}: rdata = dir1_q | (8'h01 << `PDPO_INPUT_ONLY_BIT);
			{2'b00, `PDPO_IDX_P2_DIR}: rdata = dir2_q;
			{2'b00, `PDPO_IDX_P5_DIR}: rdata = dir5_q;
			// Write-only registers answer zero so software cannot rely on them; the pin level entry is replaced by lvl_q in the APB answer
			{2'b00, `PDPO_IDX_P0_PU}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_P1_PU}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_P2_PU}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_P5_PU}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_OD_CTRL}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_DIR_SET}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_DIR_CLR}: rdata = 8'h00;
			{2'b00, `PDPO_IDX_PIN_LEVEL}: rdata = 8'h00;
			default: mapped = 1'b0;
		endcase
	end

	// ****************************************************************
	// APB answer: one cycle after setup, no wait states
	// ****************************************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			lvl_q <= 32'h00000000;
		end else begin
			lvl_q <= pin_i;
			pready_q <= setup;
			if (setup) begin
				pslverr_q <= ~mapped | (paddr[1:0] != 2'b00);
				if (idx == {2'b00, `PDPO_IDX_PIN_LEVEL})
					prdata_q <= lvl_q;
				else
					prdata_q <= {24'h000000, rdata};
			end else if (pready_q) begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h00000000;
			end
		end
	end

	// ****************************************************************
	// Direction registers with byte write and bit set/clear aliases
	// ****************************************************************
	function [7:0] dir_next;
		input [7:0] cur;
		input [7:0] impl;
		input wr_byte;
		input do_set;
		input do_clr;
		input [7:0] val;
		reg [7:0] nx;
		begin
			nx = cur;
			if (wr_byte)
				nx = val;
			if (do_set)
				nx = cur | val;
			if (do_clr)
				nx = cur & ~val;
			dir_next = nx & impl;
		end
	endfunction

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dir0_q <= `PDPO_DIR_RESET;
			dir1_q <= `PDPO_DIR_RESET;
			dir2_q <= `PDPO_DIR_RESET;
			dir5_q <= `PDPO_DIR_RESET;
		end else begin
			dir0_q <= dir_next(dir0_q, `PDPO_P0_DIR_MASK,
				wr_en && idx == {2'b00, `PDPO_IDX_P0_DIR},
				hit_dir_set && sel == 2'd0, hit_dir_clr && sel == 2'd0, mask);
			// Bit 1 of port 1 is never stored, the pin cannot drive
			dir1_q <= dir_next(dir1_q, `PDPO_P1_DIR_MASK,
				wr_en && idx == {2'b00, `PDPO_IDX_P1_DIR},
				hit_dir_set && sel == 2'd1, hit_dir_clr && sel == 2'd1, mask);
			dir2_q <= dir_next(dir2_q, `PDPO_P2_DIR_MASK,
				wr_en && idx == {2'b00, `PDPO_IDX_P2_DIR},
				hit_dir_set && sel == 2'd2, hit_dir_clr && sel == 2'd2, mask);
			dir5_q <= dir_next(dir5_q, `PDPO_P5_DIR_MASK,
				wr_en && idx == {2'b00, `PDPO_IDX_P5_DIR},
				hit_dir_set && sel == 2'd3, hit_dir_clr && sel == 2'd3, mask);
		end
	end

	// ****************************************************************
	// Pull-up and open-drain registers, whole byte writes only
	// ****************************************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pu0_q <= `PDPO_PU_RESET;
			pu1_q <= `PDPO_PU_RESET | (8'h01 << `PDPO_INPUT_ONLY_BIT);
			pu2_q <= `PDPO_PU_RESET;
			pu5_q <= `PDPO_PU_RESET;
			od_q <= `PDPO_OD_RESET;
		end else begin
			if (wr_en && idx == {2'b00, `PDPO_IDX_P0_PU})
				pu0_q <= mask & `PDPO_P0_PU_MASK;
			if (wr_en && idx == {2'b00, `PDPO_IDX_P1_PU})
				pu1_q <= (mask & `PDPO_P1_PU_MASK) | (8'h01 << `PDPO_INPUT_ONLY_BIT);
			if (wr_en && idx == {2'b00, `PDPO_IDX_P2_PU})
				pu2_q <= mask & `PDPO_P2_PU_MASK;
			if (wr_en && idx == {2'b00, `PDPO_IDX_P5_PU})
				pu5_q <= mask & `PDPO_P5_PU_MASK;
			if (wr_en && idx == {2'b00, `PDPO_IDX_OD_CTRL})
				od_q <= mask & `PDPO_OD_MASK;
		end
	end

	// Open drain is honoured only while the pin is an output; software sets that first
	assign od_vec = {23'h000000, od_q[`PDPO_OD_ENABLE_BIT], 8'h00};

	pdpo_pin_cell #(
		.NPINS(32)
	) u_pins (
		.clk(clk),
		.rst_b(rst_b),
		.dir({dir5_q, dir2_q, dir1_q, dir0_q}),
		.dir_impl(dir_impl),
		.pull({pu5_q, pu2_q, pu1_q, pu0_q}),
		.pull_impl(pu_impl),
		.od_en(od_vec),
		.data(port_data),
		.pad_o(pin_o),
		.pad_oe(pin_oe),
		.pad_pu(pin_pu)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule // pdpo_port_cfg

`default_nettype wire

// ### test/pdpo_port_cfg_properties.sv
`default_nettype none
module pdpo_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] port_data,
	input wire logic [31:0] pin_i,
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_pu
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bus and pad relations
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic setup = psel && !penable;
	wire logic rd = setup && !pwrite;
	wire logic wr = psel && penable && pready && pwrite;
	chk_ready_slot: assert property (setup |=> pready)
		else $error("ready missing after setup");
	chk_dir_drive: assert property (wr && paddr == 12'h2e0 |=> ##1 pin_oe[0] == $past(pwdata[0], 2))
		else $error("direction not on pad");
	chk_p11_reads_one: assert property (rd && paddr == 12'h304 |=> prdata[1])
		else $error("input only bit read 0");
	chk_p11_no_drive: assert property (!pin_oe[9] && !pin_pu[9])
		else $error("input only pad driven or pulled");
	chk_pullup_follow: assert property (wr && paddr == 12'h380 |=> ##1 pin_pu[0] == $past(pwdata[0], 2))
		else $error("pull-up not on pad");
	chk_wo_read_zero: assert property (rd && (paddr == 12'h384 || paddr == 12'h3a4) |=> prdata == 32'h0)
		else $error("write only register read back");
	chk_unimpl_quiet: assert property (((pin_oe | pin_pu) & 32'hefc0f2fe) == 32'h0)
		else $error("unimplemented pad active");
	chk_reset_input: assert property ($rose(rst_b) |-> pin_oe == 32'h0)
		else $error("pad driven after reset");
	cover property (wr && paddr == 12'h3a4);
	cover property (rd && paddr == 12'h304);
	cover property (pready && pslverr);
endmodule // pdpo_checker
bind pdpo_port_cfg pdpo_checker pdpo_checker_i (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .port_data(port_data), .pin_i(pin_i),
	.pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu));
`default_nettype wire

// ### test/pdpo_pin_model.sv
`default_nettype none
module pdpo_pin_model (
	input wire logic clk,
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_pu,
	output var logic [31:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Board side of the pads
	// ****
	logic [31:0] drift = 32'h0;
	// Floating pads toggle so a stale level never looks like a drive
	always @(posedge clk) begin
		drift <= ~drift;
	end
	// External resistor holds the open-drain pad high when released
	always_comb begin
		pin_i = (pin_oe & pin_o) | (~pin_oe & (pin_pu | 32'h100 | drift));
	end
endmodule // pdpo_pin_model
`default_nettype wire

// ### test/test_port_direction_pullup_opendrain.sv
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s: expected %h seen %h", n, e, g); end end
module test_port_direction_pullup_opendrain;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench
	// ****
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] port_data = 32'h0;
	wire logic [31:0] prdata, pin_i, pin_o, pin_oe, pin_pu;
	wire logic pready, pslverr;
	int errors = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic err;
	logic [9:0] dir_idx [4] = '{10'hb8, 10'hc1, 10'hc2, 10'hc5};
	logic [9:0] pu_idx [4] = '{10'he0, 10'he1, 10'he2, 10'he5};
	pdpo_port_cfg pdpo_port_cfg_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_data(port_data), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .pin_pu(pin_pu));
	pdpo_pin_model pdpo_pin_model_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_pu(pin_pu), .pin_i(pin_i));
	initial forever #25 clk = ~clk;
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in one step
		@(posedge clk);
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset;
		apb(1'b0, 10'hb8, 32'h0);
		`CHK("p0 dir", 32'h0, rd)
		apb(1'b0, 10'hc1, 32'h0);
		`CHK("p1 dir", 32'h2, rd)
		`CHK("oe", 32'h0, pin_oe)
		$display("t_reset done");
	endtask
	task automatic t_dir;
		foreach (dir_idx[i]) apb(1'b1, dir_idx[i], 32'hff);
		apb(1'b1, 10'hf1, 32'h104);
		apb(1'b0, 10'hc1, 32'h0);
		`CHK("p1 dir", 32'hb, rd)
		apb(1'b1, 10'hf0, 32'h104);
		settle();
		`CHK("oe", 32'h103f0d01, pin_oe)
		foreach (dir_idx[i]) apb(1'b1, dir_idx[i], 32'h0);
		settle();
		`CHK("oe", 32'h0, pin_oe)
		$display("t_dir done");
	endtask
	task automatic t_pull;
		foreach (pu_idx[i]) apb(1'b1, pu_idx[i], 32'hff);
		settle();
		`CHK("pu", 32'h103f0d01, pin_pu)
		apb(1'b0, 10'he1, 32'h0);
		`CHK("pu read", 32'h0, rd)
		foreach (pu_idx[i]) apb(1'b1, pu_idx[i], 32'h0);
		settle();
		`CHK("pu", 32'h0, pin_pu)
		$display("t_pull done");
	endtask
	task automatic t_od;
		port_data <= 32'h100;
		apb(1'b1, 10'hc1, 32'h1);
		apb(1'b1, 10'he9, 32'h1);
		settle();
		`CHK("od oe", 1'b0, pin_oe[8])
		apb(1'b0, 10'hf2, 32'h0);
		`CHK("od level", 1'b1, rd[8])
		port_data <= 32'h0;
		settle();
		`CHK("od low", 2'b10, {pin_oe[8], pin_o[8]})
		apb(1'b0, 10'he9, 32'h0);
		`CHK("od read", 32'h0, rd)
		port_data <= 32'h100;
		apb(1'b1, 10'he9, 32'h0);
		settle();
		`CHK("push pull", 2'b11, {pin_oe[8], pin_o[8]})
		apb(1'b0, 10'h3f, 32'h0);
		`CHK("unmapped", 1'b1, err)
		$display("t_od done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset();
		t_dir();
		t_pull();
		t_od();
		wrap_up();
	end
	initial begin
		repeat (4000) @(posedge clk);
		errors++;
		wrap_up();
	end
endmodule // test_port_direction_pullup_opendrain
`default_nettype wire
